// file: sim/physical_request_unit_bench.sv
// self-checking bench for the physical request unit
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  errors++; $display("unexpected %s expected %h seen %h", n, e, g); end end
module physical_request_unit_bench
  import pru_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] MEM_KEY = 32'h5A5A0000;
  localparam logic [31:0] ROM_BASE = 32'h00010000;
  logic sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic req_valid = 1'b0, err_on = 1'b0, slow = 1'b0;
  logic req_ready, avs_waitrequest, mem_done, mem_err, fault_irq;
  logic [6:0] avs_address = 7'h00;
  logic [31:0] avs_writedata = 32'h0, seed = 32'h5E3215FE;
  logic [31:0] avs_readdata, mem_rdata, rd, v;
  request_type req = '0;
  result_type result, res;
  mem_req_type mem_req;
  logic [63:0] fail_q[$];
  logic [47:0] off;
  logic [15:0] nd;
  int errors = 0, comparisons = 0, cycles = 0;
  req_kind_type ks[4] = '{K_LOCK, K_SELFID, K_RDQ, K_WRQ};
  logic [47:0] os[4] = '{48'h0, 48'h0, 48'h0, 48'h000100000000};
  physical_request_unit u_physical_request_unit (.sys_clk(sys_clk),
    .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .result(result), .mem_req(mem_req), .mem_done(mem_done),
    .mem_err(mem_err), .mem_rdata(mem_rdata), .fault_irq(fault_irq));
  pru_mem_model u_pru_mem_model (.sys_clk(sys_clk), .rst(rst),
    .mem_req(mem_req), .err_on(err_on), .slow(slow), .mem_done(mem_done),
    .mem_err(mem_err), .mem_rdata(mem_rdata));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one idle edge first so a strobe is never assigned twice in a time step
  task automatic av(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic send(input req_kind_type k, input logic [15:0] n,
    input logic [47:0] o, input logic [31:0] d, input logic [31:0] a);
    @(posedge sys_clk);
    req <= '{k, n, o, 16'h0004, d, a};
    req_valid <= 1'b1;
    do @(posedge sys_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do @(posedge sys_clk); while (result.valid !== 1'b1);
    res = result;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    av(1'b0, REG_RSRC_FIRST, 32'h0);
    `CHK("manager reset", RST_MANAGER, rd)
    av(1'b1, 7'h7C, 32'hFFFFFFFF);
    av(1'b0, 7'h7C, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    for (int i = 0; i < 4; i++) begin
      av(1'b1, REG_ALL_MASK_HI + 7'(4 * i), 32'hFFFFFFFF);
    end
    av(1'b1, REG_MASK, 32'h1);
    av(1'b1, REG_ROM_BASE, ROM_BASE);
    for (int i = 0; i < 5; i++) begin
      v = $random(seed);
      av(1'b1, REG_ROM_LOCAL_FIRST + 7'(4 * i), v);
      send(K_RDQ, 16'h0003, OFF_ROM_FIRST + 48'(4 * i), 32'h0, 32'h0);
      `CHK("rom local", v, res.data)
    end
    send(K_LOCK, 16'h0003, OFF_RSRC_FIRST, 32'h5, RST_MANAGER);
    send(K_RDQ, 16'h0003, OFF_RSRC_FIRST, 32'h0, 32'h0);
    `CHK("swap stored", 32'h5, res.data)
    for (int i = 0; i < 4; i++) begin
      send(K_WRQ, 16'h0003, OFF_RSRC_FIRST + 48'(4 * i), 32'h0, 32'h0);
      `CHK("resource ack", ACK_TYPE_ERROR, res.ack)
    end
    $display("test local service done");
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      err_on <= (i == 5);
      off = {16'h0, $random(seed)} & 48'hFFFFFFFFFFFC;
      send(K_RDQ, 16'(i + 1), off, 32'h0, 32'h0);
      v = 32'(i == 5 ? RESP_DATA_ERROR : RESP_COMPLETE);
      `CHK("rcode", v[3:0], res.rcode)
      if (i < 5) begin
        `CHK("direct data", off[31:0] ^ MEM_KEY, res.data)
      end
    end
    err_on <= 1'b0;
    send(K_RDQ, 16'h0003, OFF_ROM_WIN_FIRST, 32'h0, 32'h0);
    `CHK("rom window", (ROM_BASE | 32'h14) ^ MEM_KEY, res.data)
    `CHK("read irq", 1'b0, fault_irq)
    av(1'b1, REG_DIR_MASK_LO, 32'hFFFFFFFE);
    for (int i = 0; i < 4; i++) begin
      send(ks[i], 16'h0000, os[i], 32'h0, 32'h0);
      `CHK("to context", 1'b1, res.to_ar)
    end
    av(1'b1, REG_DIR_MASK_LO, 32'hFFFFFFFF);
    send(K_WRQ, 16'h0003, 48'h000000001000, 32'h0, 32'h0);
    `CHK("unposted ack", ACK_PENDING, res.ack)
    `CHK("unposted mem", 1'b0, mem_req.valid)
    $display("test routing done");
    av(1'b1, REG_CONTROL, 32'h1);
    // a slow memory would sample err_on after the next write has changed it
    slow <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      err_on <= (i < 4);
      nd = 16'($random(seed)) & 16'h003F;
      off = {16'h0, $random(seed)} & 48'hFFFFFFFFFFFC;
      send(K_WRQ, nd, off, $random(seed), 32'h0);
      v = 32'(i < 4 ? ACK_COMPLETE : ACK_PENDING);
      `CHK("posted ack", v[3:0], res.ack)
      if (i < 4) begin
        fail_q.push_back({nd, off});
      end
    end
    repeat (4) @(posedge sys_clk);
    av(1'b0, REG_QUEUE_STATUS, 32'h0);
    `CHK("queue count", 32'(PW_DEPTH), rd)
    `CHK("fault irq", 1'b1, fault_irq)
    while (fail_q.size() > 0) begin
      av(1'b1, REG_EVENT, 32'h1);
      // a write to the fault register must leave the entry untouched
      av(1'b1, REG_FAIL_HIGH, ~fail_q[0][63:32]);
      av(1'b0, REG_FAIL_HIGH, 32'h0);
      `CHK("fail high", fail_q[0][63:32], rd)
      av(1'b0, REG_FAIL_LOW, 32'h0);
      `CHK("fail low", fail_q[0][31:0], rd)
      void'(fail_q.pop_front());
      repeat (3) @(posedge sys_clk);
      `CHK("next irq", fail_q.size() > 0, fault_irq)
    end
    av(1'b1, REG_MASK, 32'h0);
    err_on <= 1'b1;
    send(K_WRQ, 16'h0002, 48'h000000002000, 32'h0, 32'h0);
    repeat (8) @(posedge sys_clk);
    `CHK("masked irq", 1'b0, fault_irq)
    av(1'b0, REG_EVENT, 32'h0);
    `CHK("event bit", 32'h1, rd & 32'h1)
    $display("test posted writes done");
    stop_test();
  end
endmodule
`default_nettype wire

// file: sim/pru_assertions.sv
// port assertions for the physical request unit
`default_nettype none
module pru_assertions
  import pru_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire request_type req,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire result_type result,
  input wire mem_req_type mem_req,
  input wire logic mem_done,
  input wire logic mem_err,
  input wire logic [31:0] mem_rdata,
  input wire logic fault_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic taken, rd_q, in_rsrc, in_rom, in_win;
  assign taken = req_valid && req_ready;
  assign rd_q = taken && req.kind == K_RDQ;
  assign in_rsrc = req.offset >= OFF_RSRC_FIRST
                   && req.offset <= OFF_RSRC_LAST;
  assign in_rom = req.offset >= OFF_ROM_FIRST
                  && req.offset <= OFF_ROM_LOCAL_LAST;
  assign in_win = req.offset >= OFF_ROM_WIN_FIRST
                  && req.offset <= OFF_ROM_WIN_LAST;
  ////////////////////////////////////////////////////////////////////////
  wait_once_a: assert property ((avs_read || avs_write)
    && avs_waitrequest |=> !avs_waitrequest) else $error("wait too long");
  lock_route_a: assert property (taken && req.kind == K_LOCK
    && req.offset[47:32] == PHYS_HI |=> result.valid && result.to_ar)
    else $error("lock not diverted");
  selfid_route_a: assert property (taken && req.kind == K_SELFID
    |=> result.valid && result.to_ar) else $error("self id not diverted");
  rsrc_type_a: assert property (taken && in_rsrc
    && req.kind == K_WRQ |=> result.valid && result.ack == ACK_TYPE_ERROR)
    else $error("resource write not refused");
  rom_local_a: assert property (rd_q && in_rom
    |=> result.valid && !result.to_ar && !mem_req.valid)
    else $error("rom quadlet not local");
  rom_window_a: assert property (rd_q && in_win
    |=> mem_req.valid && mem_req.addr[9:0] == $past(req.offset[9:0]))
    else $error("rom window address wrong");
  phys_addr_a: assert property ($rose(mem_req.valid)
    && $past(req.offset[47:32]) == PHYS_HI
    |-> mem_req.addr == $past(req.offset[31:0])) else $error("bad address");
  mem_hold_a: assert property (mem_req.valid && !mem_done
    |=> mem_req.valid && $stable(mem_req)) else $error("memory request moved");
  busy_refuse_a: assert property (mem_req.valid |-> !req_ready)
    else $error("request taken while memory busy");
  read_quiet_a: assert property (mem_done && mem_err
    && !mem_req.write && !fault_irq |=> !fault_irq [*3])
    else $error("read raised interrupt");
endmodule
bind physical_request_unit pru_assertions u_pru_assertions (
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .req(req),
  .req_valid(req_valid), .req_ready(req_ready), .result(result),
  .mem_req(mem_req), .mem_done(mem_done), .mem_err(mem_err),
  .mem_rdata(mem_rdata), .fault_irq(fault_irq));
`default_nettype wire

// file: sim/pru_mem_model.sv
// host memory stand-in answering the unit's memory requests
`default_nettype none
module pru_mem_model
  import pru_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire mem_req_type mem_req,
  input wire logic err_on,
  input wire logic slow,
  output logic mem_done,
  output logic mem_err,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] MEM_KEY = 32'h5A5A0000;
  int wait_cnt;
  always @(posedge sys_clk) begin
    mem_done <= 1'b0;
    mem_err <= 1'b0;
    // stale read data flips every cycle so it never passes for an answer
    mem_rdata <= rst ? 32'h0 : ~mem_rdata;
    if (rst || !mem_req.valid || mem_done) begin
      wait_cnt <= slow ? 3 : 0;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end else begin
      mem_done <= 1'b1;
      mem_err <= err_on;
      mem_rdata <= mem_req.addr ^ MEM_KEY;
    end
  end
endmodule
`default_nettype wire

// file: src/physical_request_unit.sv
// physical request unit: request decode, direct service, posted writes
//
// Operation
// RULE1 - late self-id packets go to the request receive context
// RULE2 - zero upper offset: low 32 bits address host memory; reads answered
// RULE3 - lock requests to host-memory space go to the receive context
// RULE4 - direct access needs node enabled in both source masks
// RULE5 - resource registers serve reads and compare-swap; else type error
// RULE6 - rom header, bus name, capability, unique id read locally
// RULE7 - other rom quadlets read from a 1K window at rom base
// RULE8 - anything not handled directly goes to the receive context
// RULE9 - node blocked only for direct access goes to receive context
// RULE10 - unposted writes report complete only after memory write
// RULE11 - pending posted writes keep requester node and 48-bit offset
// RULE12 - failed posted write sets fault event and stays pending
// RULE13 - clearing fault event retires reported write; may set again
// RULE14 - posting limited to queue depth; beyond it ack pending
// RULE15 - slot freed on successful write or software removal
// RULE16 - read-only fault registers show node and offset halves
// RULE17 - failed write queued, event raised, packet dropped from flow
// RULE18 - consumed head advances queue, event again; empty stops it
// RULE19 - read of low fault register consumes the head entry
// RULE20 - software clears event, reads high then low fault register
// RULE21 - without posting support never post nor report faults
// RULE22 - reads never interrupt; writes only on posted-write failure
// RULE23 - queue depth is a parameter; interrupt gated by event mask
`default_nettype none
module physical_request_unit
  import pru_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire request_type req,
  input wire logic req_valid,
  output logic req_ready,
  output result_type result,
  output mem_req_type mem_req,
  input wire logic mem_done,
  input wire logic mem_err,
  input wire logic [31:0] mem_rdata,
  output logic fault_irq
);

  typedef enum logic [0:0] {S_IDLE, S_MEM} phase_type;

  typedef struct packed {
    phase_type phase;
    logic posted;
    request_type cur;
    result_type res;
    mem_req_type mem;
    logic post_on;
    logic fault;
    logic fault_mask;
    logic [63:0] all_mask;
    logic [63:0] dir_mask;
    logic [31:0] rom_base;
    logic [3:0][31:0] rsrc;
    logic [4:0][31:0] rom;
    logic [PW_DEPTH-1:0][63:0] q;
    logic [QW-1:0] head;
    logic [QW-1:0] tail;
    logic [QW:0] cnt;
    logic rel;
    logic bus_done;
    logic [31:0] rdata;
  } state_type;

  state_type s_reg;
  state_type s_next;

  function automatic result_type answer(input logic to_ar,
                                        input logic [3:0] ack,
                                        input logic [3:0] rcode,
                                        input logic [31:0] data);
    answer = '{1'b1, to_ar, ack, rcode, data};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [63:0] head_e;
    logic [6:0] d_rs;
    logic [6:0] d_rom;
    logic [31:0] rd;
    logic [NODE_W-1:0] nd;
    logic [1:0] rid;
    logic [QW:0] used;
    logic push;
    logic pop;
    logic clr;
    logic set_ev;
    logic ok;
    logic can_post;
    logic wr_go;
    logic rd_go;
    head_e = s_reg.q[s_reg.head];
    d_rs = avs_address - REG_RSRC_FIRST;
    d_rom = avs_address - REG_ROM_LOCAL_FIRST;
    rd = 32'h00000000;
    nd = req.node[NODE_W-1:0];
    rid = req.offset[3:2] + 2'h1;
    push = 1'b0;
    pop = 1'b0;
    clr = 1'b0;
    ok = s_reg.all_mask[nd] & s_reg.dir_mask[nd];
    // a slot stays taken until written or released by software
    used = s_reg.cnt - (QW+1)'(s_reg.rel)
         + (QW+1)'(s_reg.phase == S_MEM && s_reg.posted); // see RULE15
    can_post = POST_SUPPORT && s_reg.post_on
             && used < (QW+1)'(PW_DEPTH); // see RULE14 see RULE21
    wr_go = s_reg.bus_done & avs_write;
    rd_go = s_reg.bus_done & avs_read;
    n_init: begin
      s_next = s_reg;
    end
    s_next.res.valid = 1'b0;
    s_next.bus_done = 1'b0;

    //////////////////////////////////////////////////////////////////////
    // register read mux, sampled in the first bus cycle
    case (avs_address)
      REG_CONTROL: rd[POST_BIT] = s_reg.post_on;
      REG_EVENT: rd[FAULT_BIT] = s_reg.fault;
      REG_MASK: rd[FAULT_BIT] = s_reg.fault_mask;
      REG_ALL_MASK_HI: rd = s_reg.all_mask[63:32];
      REG_ALL_MASK_LO: rd = s_reg.all_mask[31:0];
      REG_DIR_MASK_HI: rd = s_reg.dir_mask[63:32];
      REG_DIR_MASK_LO: rd = s_reg.dir_mask[31:0];
      REG_ROM_BASE: rd = s_reg.rom_base;
      REG_FAIL_HIGH: rd = head_e[63:32]; // see RULE16
      REG_FAIL_LOW: rd = head_e[31:0]; // see RULE16
      REG_QUEUE_STATUS: rd = 32'(s_reg.cnt);
      default: begin
        if (avs_address >= REG_RSRC_FIRST && avs_address <= REG_RSRC_LAST)
          rd = s_reg.rsrc[d_rs[3:2]];
        else if (avs_address >= REG_ROM_LOCAL_FIRST
                 && avs_address <= REG_ROM_LOCAL_LAST)
          rd = s_reg.rom[d_rom[4:2]];
      end
    endcase
    if ((avs_read | avs_write) & ~s_reg.bus_done) begin
      s_next.bus_done = 1'b1;
      s_next.rdata = rd;
    end

    // register writes take effect at the edge that ends the transfer, one cycle after waitrequest drops
    if (wr_go) begin
      case (avs_address)
        REG_CONTROL: s_next.post_on = avs_writedata[POST_BIT];
        REG_EVENT: clr = avs_writedata[FAULT_BIT];
        REG_MASK: s_next.fault_mask = avs_writedata[FAULT_BIT];
        REG_ALL_MASK_HI: s_next.all_mask[63:32] = avs_writedata;
        REG_ALL_MASK_LO: s_next.all_mask[31:0] = avs_writedata;
        REG_DIR_MASK_HI: s_next.dir_mask[63:32] = avs_writedata;
        REG_DIR_MASK_LO: s_next.dir_mask[31:0] = avs_writedata;
        REG_ROM_BASE: s_next.rom_base = avs_writedata;
        default: begin
          if (avs_address >= REG_RSRC_FIRST
              && avs_address <= REG_RSRC_LAST)
            s_next.rsrc[d_rs[3:2]] = avs_writedata;
          else if (avs_address >= REG_ROM_LOCAL_FIRST
                   && avs_address <= REG_ROM_LOCAL_LAST)
            s_next.rom[d_rom[4:2]] = avs_writedata;
        end
      endcase
    end
    // a read of the low fault register consumes the head entry
    if (rd_go && avs_address == REG_FAIL_LOW && s_reg.cnt != '0)
      pop = 1'b1; // see RULE19
    // the release frees the slot; the entry stays visible until the low read, except that with a full queue
    // a posted write failing before then overwrites it; otherwise software following its clear-high-low order sees it whole
    if (clr && s_reg.fault && s_reg.cnt != '0)
      s_next.rel = 1'b1; // see RULE13 see RULE20

    //////////////////////////////////////////////////////////////////////
    // request decode
    if (s_reg.phase == S_IDLE && req_valid) begin
      s_next.cur = req;
      s_next.res = answer(1'b1, ACK_PENDING, RESP_COMPLETE, 32'h00000000);
      if (req.kind == K_SELFID) begin
        s_next.res.to_ar = 1'b1; // see RULE1
      end else if (req.offset[47:32] == PHYS_HI) begin
        if (req.kind == K_LOCK) begin
          s_next.res.to_ar = 1'b1; // see RULE3
        end else if (!ok) begin
          s_next.res.to_ar = 1'b1; // see RULE4 see RULE9
        end else if (req.kind == K_RDQ || req.kind == K_RDB) begin
          s_next.res.valid = 1'b0;
          s_next.mem = '{1'b1, 1'b0, req.offset[31:0], req.len,
                         32'h00000000}; // see RULE2
          s_next.posted = 1'b0;
          s_next.phase = S_MEM;
        end else if (req.kind == K_WRQ || req.kind == K_WRB) begin
          s_next.mem = '{1'b1, 1'b1, req.offset[31:0], req.len,
                         req.data}; // see RULE2
          s_next.phase = S_MEM;
          s_next.posted = can_post;
          if (can_post)
            s_next.res = answer(1'b0, ACK_COMPLETE, RESP_COMPLETE,
                                32'h00000000); // see RULE14
          else
            s_next.res.valid = 1'b0; // see RULE10
        end else begin
          s_next.res.to_ar = 1'b1; // see RULE8
        end
      end else if (req.offset >= OFF_RSRC_FIRST
                   && req.offset <= OFF_RSRC_LAST
                   && req.offset[1:0] == 2'h0) begin
        if (req.kind == K_RDQ) begin
          s_next.res = answer(1'b0, ACK_PENDING, RESP_COMPLETE,
                              s_reg.rsrc[rid]); // see RULE5
        end else if (req.kind == K_LOCK) begin
          s_next.res = answer(1'b0, ACK_PENDING, RESP_COMPLETE,
                              s_reg.rsrc[rid]); // see RULE5
          if (s_reg.rsrc[rid] == req.arg)
            s_next.rsrc[rid] = req.data;
        end else begin
          s_next.res = answer(1'b0, ACK_TYPE_ERROR, RESP_COMPLETE,
                              32'h00000000); // see RULE5
        end
      end else if (req.kind == K_RDQ && req.offset >= OFF_ROM_FIRST
                   && req.offset <= OFF_ROM_LOCAL_LAST
                   && req.offset[1:0] == 2'h0) begin
        s_next.res = answer(1'b0, ACK_PENDING, RESP_COMPLETE,
                            s_reg.rom[req.offset[4:2]]); // see RULE6
      end else if (req.kind == K_RDQ && req.offset >= OFF_ROM_WIN_FIRST
                   && req.offset <= OFF_ROM_WIN_LAST) begin
        s_next.res.valid = 1'b0;
        s_next.mem = '{1'b1, 1'b0,
                       {s_reg.rom_base[31:ROM_WIN_BITS],
                        req.offset[ROM_WIN_BITS-1:0]},
                       req.len, 32'h00000000}; // see RULE7
        s_next.posted = 1'b0;
        s_next.phase = S_MEM;
      end else begin
        s_next.res.to_ar = 1'b1; // see RULE8
      end
    end

    //////////////////////////////////////////////////////////////////////
    // host memory completion
    if (s_reg.phase == S_MEM && mem_done) begin
      s_next.mem.valid = 1'b0;
      s_next.phase = S_IDLE;
      if (s_reg.posted) begin
        // failed posted data is dropped here so later traffic flows
        if (mem_err)
          push = 1'b1; // see RULE12 see RULE17
      end else begin
        s_next.res = answer(1'b0, ACK_PENDING,
                            mem_err ? RESP_DATA_ERROR : RESP_COMPLETE,
                            s_reg.mem.write ? 32'h00000000 : mem_rdata);
      end // see RULE10
    end

    //////////////////////////////////////////////////////////////////////
    // posted-write error queue
    if (push)
      s_next.q[s_reg.tail] = {s_reg.cur.node, s_reg.cur.offset}; // see RULE11
    if (push)
      s_next.tail = s_reg.tail + QW'(1);
    if (pop) begin
      s_next.head = s_reg.head + QW'(1); // see RULE18
      s_next.rel = 1'b0; // see RULE15
    end
    s_next.cnt = s_reg.cnt + (QW+1)'(push) - (QW+1)'(pop);
    set_ev = (push && s_reg.cnt == '0)
           || (pop && s_next.cnt != '0); // see RULE18
    // a new event in the clearing cycle wins over the clear
    s_next.fault = (s_reg.fault & ~clr) | set_ev; // see RULE12

    if (rst) begin
      s_next = '0;
      s_next.rsrc[0] = RST_MANAGER;
    end
  end

  always_ff @(posedge sys_clk) begin
    s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////
  assign avs_waitrequest = (avs_read | avs_write) & ~s_reg.bus_done;
  assign avs_readdata = s_reg.rdata;
  assign req_ready = (s_reg.phase == S_IDLE);
  assign result = s_reg.res;
  assign mem_req = s_reg.mem;
  // only the posted-write fault reaches the interrupt line
  assign fault_irq = s_reg.fault & s_reg.fault_mask; // see RULE22 see RULE23

endmodule
`default_nettype wire

// file: src/pru_pkg.sv
// package: constants and carrier types of the physical request unit
`default_nettype none
package pru_pkg;
  // posted-write error queue
  localparam int PW_DEPTH = 4;
  localparam int QW = $clog2(PW_DEPTH);
  localparam bit POST_SUPPORT = 1'b1;
  localparam int NODE_W = 6;

  // serial-bus destination offsets
  localparam logic [15:0] PHYS_HI = 16'h0000;
  localparam logic [47:0] OFF_RSRC_FIRST = 48'hFFFFF000021C;
  localparam logic [47:0] OFF_RSRC_LAST = 48'hFFFFF0000228;
  localparam logic [47:0] OFF_ROM_FIRST = 48'hFFFFF0000400;
  localparam logic [47:0] OFF_ROM_LOCAL_LAST = 48'hFFFFF0000410;
  localparam logic [47:0] OFF_ROM_WIN_FIRST = 48'hFFFFF0000414;
  localparam logic [47:0] OFF_ROM_WIN_LAST = 48'hFFFFF00007FF;
  localparam int ROM_WIN_BITS = 10;

  // acknowledge and response codes
  localparam logic [3:0] ACK_COMPLETE = 4'h1;
  localparam logic [3:0] ACK_PENDING = 4'h2;
  localparam logic [3:0] ACK_TYPE_ERROR = 4'hE;
  localparam logic [3:0] RESP_COMPLETE = 4'h0;
  localparam logic [3:0] RESP_DATA_ERROR = 4'h5;

  // register byte addresses
  localparam logic [6:0] REG_CONTROL = 7'h00;
  localparam logic [6:0] REG_EVENT = 7'h04;
  localparam logic [6:0] REG_MASK = 7'h08;
  localparam logic [6:0] REG_ALL_MASK_HI = 7'h0C;
  localparam logic [6:0] REG_ALL_MASK_LO = 7'h10;
  localparam logic [6:0] REG_DIR_MASK_HI = 7'h14;
  localparam logic [6:0] REG_DIR_MASK_LO = 7'h18;
  localparam logic [6:0] REG_ROM_BASE = 7'h1C;
  localparam logic [6:0] REG_RSRC_FIRST = 7'h20;
  localparam logic [6:0] REG_RSRC_LAST = 7'h2C;
  localparam logic [6:0] REG_ROM_LOCAL_FIRST = 7'h30;
  localparam logic [6:0] REG_ROM_LOCAL_LAST = 7'h40;
  localparam logic [6:0] REG_FAIL_HIGH = 7'h44;
  localparam logic [6:0] REG_FAIL_LOW = 7'h48;
  localparam logic [6:0] REG_QUEUE_STATUS = 7'h4C;

  // field positions and reset values
  localparam int POST_BIT = 0;
  localparam int FAULT_BIT = 0;
  localparam logic [31:0] RST_MANAGER = 32'h0000003F;

  typedef enum logic [2:0] {
    K_RDQ, K_RDB, K_WRQ, K_WRB, K_LOCK, K_SELFID, K_OTHER
  } req_kind_type;

  typedef struct packed {
    req_kind_type kind;
    logic [15:0] node;
    logic [47:0] offset;
    logic [15:0] len;
    logic [31:0] data;
    logic [31:0] arg;
  } request_type;

  typedef struct packed {
    logic valid;
    logic to_ar;
    logic [3:0] ack;
    logic [3:0] rcode;
    logic [31:0] data;
  } result_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [15:0] len;
    logic [31:0] data;
  } mem_req_type;
endpackage
`default_nettype wire
